// *** pkrim_top.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - The two-bit key reset select picks pins 0-3, 0-2, 0-1 of port 0, or none at code zero.
// - While enabled, all selected port-0 pins low together raise an initial reset request.
// - The key reset select returns to off at initial reset, so it is never a power-on source.
// - Each pin has an input enable bit, set after reset, that passes or blocks its level.
// - Enable bits of pins absent on this variant are reserved and read as zero.
// - Pin 3 field (bits 7-6) at code one feeds the pin to the ADC trigger input.
// - Pin 2 field (bits 5-4) defaults to port use, which also feeds the timer clock input.
// - Pin 1 field (bits 3-2) at code one feeds the pin to the remote receive input.
// - Pin 0 field (bits 1-0) at code one drives the pin from the remote transmit output.
// - Pins 0-3 of port 0 are shared, and each function field resets to port use.
module pkrim_top (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [7:0] port0_pin_i,
   input wire logic [7:0] port1_pin_i,
   input wire logic [7:0] port2_pin_i,
   input wire logic [7:0] port3_pin_i,
   input wire logic [7:0] port4_pin_i,
   input wire logic [7:0] port5_pin_i,
   output logic [7:0] port0_input_data_o,
   output logic [7:0] port1_input_data_o,
   output logic [7:0] port2_input_data_o,
   output logic [7:0] port3_input_data_o,
   output logic [7:0] port4_input_data_o,
   output logic [7:0] port5_input_data_o,
   input wire logic [3:0] gpio_low_out_i,
   input wire logic [3:0] gpio_low_oe_i,
   output logic [3:0] low_pin_out_o,
   output logic [3:0] low_pin_oe_o,
   input wire logic remote_transmit_out_i,
   output logic remote_receive_in_o,
   output logic adc_trigger_input_n_o,
   output logic timer_ext_clock_in_o,
   output logic key_reset_req_o
);

   // Presence masks gathered per port index
   localparam logic [7:0] PRESENT [pkrim_pkg::NUM_PORTS] = '{
      pkrim_pkg::PORT0_PRESENT,
      pkrim_pkg::PORT1_PRESENT,
      pkrim_pkg::PORT2_PRESENT,
      pkrim_pkg::PORT3_PRESENT,
      pkrim_pkg::PORT4_PRESENT,
      pkrim_pkg::PORT5_PRESENT
   };

   localparam logic [15:0] IEN_OFS [pkrim_pkg::NUM_PORTS] = '{
      pkrim_pkg::PORT0_INPUT_ENABLE_OFS,
      pkrim_pkg::PORT1_INPUT_ENABLE_OFS,
      pkrim_pkg::PORT2_INPUT_ENABLE_OFS,
      pkrim_pkg::PORT3_INPUT_ENABLE_OFS,
      pkrim_pkg::PORT4_INPUT_ENABLE_OFS,
      pkrim_pkg::PORT5_INPUT_ENABLE_OFS
   };

   // Register state
   logic [1:0] key_reset_select_ff;
   logic [7:0] low_pin_function_select_ff;
   logic [7:0] pin_input_enable_bits_ff [pkrim_pkg::NUM_PORTS];
   logic [7:0] reg_rdata_ff;

   // Registered pin-side outputs
   logic [7:0] input_data_ff [pkrim_pkg::NUM_PORTS];
   logic [3:0] low_pin_out_ff;
   logic [3:0] low_pin_oe_ff;
   logic remote_receive_ff;
   logic adc_trigger_n_ff;
   logic timer_clock_ff;

   // Raw pin levels gathered per port index
   wire [7:0] pin_level [pkrim_pkg::NUM_PORTS];
   assign pin_level[0] = port0_pin_i;
   assign pin_level[1] = port1_pin_i;
   assign pin_level[2] = port2_pin_i;
   assign pin_level[3] = port3_pin_i;
   assign pin_level[4] = port4_pin_i;
   assign pin_level[5] = port5_pin_i;

   // Address decode
   wire key_hit;
   wire func_hit;
   wire [pkrim_pkg::NUM_PORTS-1:0] ien_hit;
   wire any_hit;

   assign key_hit = (reg_addr_i == pkrim_pkg::KEY_RESET_CONFIG_OFS);
   assign func_hit = (reg_addr_i == pkrim_pkg::LOW_PIN_FUNCTION_SELECT_OFS);
   assign any_hit = key_hit || func_hit || (ien_hit != '0);

   // Write strobes
   wire key_wr;
   wire func_wr;
   assign key_wr = reg_wr_i && key_hit;
   assign func_wr = reg_wr_i && func_hit;

   // Function fields
   wire [1:0] pin3_function_field;
   wire [1:0] pin2_function_field;
   wire [1:0] pin1_function_field;
   wire [1:0] pin0_function_field;
   assign pin3_function_field = low_pin_function_select_ff[pkrim_pkg::PIN3_FIELD_LSB +: 2];
   assign pin2_function_field = low_pin_function_select_ff[pkrim_pkg::PIN2_FIELD_LSB +: 2];
   assign pin1_function_field = low_pin_function_select_ff[pkrim_pkg::PIN1_FIELD_LSB +: 2];
   assign pin0_function_field = low_pin_function_select_ff[pkrim_pkg::PIN0_FIELD_LSB +: 2];

   wire pin3_is_adc;
   wire pin2_is_gpio;
   wire pin1_is_remote;
   wire pin0_is_remote;
   assign pin3_is_adc = (pin3_function_field == pkrim_pkg::FUNC_PERIPH);
   assign pin2_is_gpio = (pin2_function_field == pkrim_pkg::FUNC_GPIO);
   assign pin1_is_remote = (pin1_function_field == pkrim_pkg::FUNC_PERIPH);
   assign pin0_is_remote = (pin0_function_field == pkrim_pkg::FUNC_PERIPH);

   // Input gating and per-port enable registers
   wire [7:0] gated_level [pkrim_pkg::NUM_PORTS];
   wire [7:0] ien_read [pkrim_pkg::NUM_PORTS];

   genvar gp;
   generate
      for (gp = 0; gp < pkrim_pkg::NUM_PORTS; gp++) begin : g_port
         wire ien_wr;
         assign ien_hit[gp] = (reg_addr_i == IEN_OFS[gp]);
         assign ien_wr = reg_wr_i && ien_hit[gp];
         // Absent pins reset to one but are masked on read, so they read as zero
         assign ien_read[gp] = pin_input_enable_bits_ff[gp] & PRESENT[gp];
         assign gated_level[gp] = pin_level[gp] & ien_read[gp];

         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               pin_input_enable_bits_ff[gp] <= pkrim_pkg::INPUT_ENABLE_RST;
            end else if (ien_wr) begin
               pin_input_enable_bits_ff[gp] <= reg_wdata_i & PRESENT[gp];
            end
         end

         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               input_data_ff[gp] <= 8'h00;
            end else begin
               input_data_ff[gp] <= gated_level[gp];
            end
         end
      end
   endgenerate

   assign port0_input_data_o = input_data_ff[0];
   assign port1_input_data_o = input_data_ff[1];
   assign port2_input_data_o = input_data_ff[2];
   assign port3_input_data_o = input_data_ff[3];
   assign port4_input_data_o = input_data_ff[4];
   assign port5_input_data_o = input_data_ff[5];

   // Configuration registers
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         key_reset_select_ff <= pkrim_pkg::KEY_RESET_SELECT_RST;
      end else if (key_wr) begin
         key_reset_select_ff <= reg_wdata_i[pkrim_pkg::KEY_SELECT_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         low_pin_function_select_ff <= pkrim_pkg::LOW_PIN_FUNCTION_SELECT_RST;
      end else if (func_wr) begin
         low_pin_function_select_ff <= reg_wdata_i;
      end
   end

   // Read mux; unmapped addresses return zero
   wire [7:0] key_read;
   wire [7:0] ien_sel_read;
   wire [7:0] nxt_rdata;

   assign key_read = {6'h00, key_reset_select_ff};

   logic [7:0] ien_or;
   always_comb begin
      ien_or = 8'h00;
      for (int i = 0; i < pkrim_pkg::NUM_PORTS; i++) begin
         if (ien_hit[i]) begin
            ien_or = ien_or | ien_read[i];
         end
      end
   end
   assign ien_sel_read = ien_or;

   assign nxt_rdata = !any_hit ? 8'h00 :
                      key_hit ? key_read :
                      func_hit ? low_pin_function_select_ff :
                      ien_sel_read;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata_o = reg_rdata_ff;

   // Pin routing for port 0, pins 0 to 3
   wire [3:0] nxt_low_out;
   wire [3:0] nxt_low_oe;
   wire nxt_remote_receive;
   wire nxt_adc_trigger_n;
   wire nxt_timer_clock;

   assign nxt_low_out[0] = pin0_is_remote ? remote_transmit_out_i : gpio_low_out_i[0];
   assign nxt_low_oe[0] = pin0_is_remote ? 1'b1 : gpio_low_oe_i[0];
   assign nxt_low_out[1] = pin1_is_remote ? 1'b0 : gpio_low_out_i[1];
   assign nxt_low_oe[1] = pin1_is_remote ? 1'b0 : gpio_low_oe_i[1];
   // Pin 2 stays a port pin; timer clock works when software keeps its driver off
   assign nxt_low_out[2] = gpio_low_out_i[2];
   assign nxt_low_oe[2] = gpio_low_oe_i[2];
   assign nxt_low_out[3] = pin3_is_adc ? 1'b0 : gpio_low_out_i[3];
   assign nxt_low_oe[3] = pin3_is_adc ? 1'b0 : gpio_low_oe_i[3];

   assign nxt_remote_receive = pin1_is_remote && gated_level[0][1];
   // Trigger is active low, so it idles high when not routed
   assign nxt_adc_trigger_n = pin3_is_adc ? gated_level[0][3] : 1'b1;
   assign nxt_timer_clock = pin2_is_gpio && gated_level[0][2];

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         low_pin_out_ff <= 4'h0;
         low_pin_oe_ff <= 4'h0;
         remote_receive_ff <= 1'b0;
         adc_trigger_n_ff <= 1'b1;
         timer_clock_ff <= 1'b0;
      end else begin
         low_pin_out_ff <= nxt_low_out;
         low_pin_oe_ff <= nxt_low_oe;
         remote_receive_ff <= nxt_remote_receive;
         adc_trigger_n_ff <= nxt_adc_trigger_n;
         timer_clock_ff <= nxt_timer_clock;
      end
   end

   assign low_pin_out_o = low_pin_out_ff;
   assign low_pin_oe_o = low_pin_oe_ff;
   assign remote_receive_in_o = remote_receive_ff;
   assign adc_trigger_input_n_o = adc_trigger_n_ff;
   assign timer_ext_clock_in_o = timer_clock_ff;

   // Key-entry reset watches raw pin levels, independent of input enables
   pkrim_key_reset u_key_reset (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .key_reset_select_i(key_reset_select_ff),
      .key_pin_i(port0_pin_i[3:0]),
      .key_reset_req_o(key_reset_req_o)
   );

endmodule

`default_nettype wire

// *** pkrim_pkg.sv ***
`default_nettype none

package pkrim_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_PORTS = 6;
   localparam int KEY_PINS = 4;

   // Register offsets
   localparam logic [15:0] KEY_RESET_CONFIG_OFS = 16'h5209;
   localparam logic [15:0] PORT0_INPUT_ENABLE_OFS = 16'h520a;
   localparam logic [15:0] PORT1_INPUT_ENABLE_OFS = 16'h521a;
   localparam logic [15:0] PORT2_INPUT_ENABLE_OFS = 16'h522a;
   localparam logic [15:0] PORT3_INPUT_ENABLE_OFS = 16'h523a;
   localparam logic [15:0] PORT4_INPUT_ENABLE_OFS = 16'h524a;
   localparam logic [15:0] PORT5_INPUT_ENABLE_OFS = 16'h525a;
   localparam logic [15:0] LOW_PIN_FUNCTION_SELECT_OFS = 16'h52a0;

   // Values after reset
   localparam logic [1:0] KEY_RESET_SELECT_RST = 2'h0;
   localparam logic [7:0] INPUT_ENABLE_RST = 8'hff;
   localparam logic [7:0] LOW_PIN_FUNCTION_SELECT_RST = 8'h00;

   // Field positions in the function select and key reset config registers
   localparam int PIN3_FIELD_LSB = 6;
   localparam int PIN2_FIELD_LSB = 4;
   localparam int PIN1_FIELD_LSB = 2;
   localparam int PIN0_FIELD_LSB = 0;
   localparam int KEY_SELECT_LSB = 0;

   // Function field codes
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_PERIPH = 2'h1;

   // Key reset select codes
   localparam logic [1:0] KEY_OFF = 2'h0;
   localparam logic [1:0] KEY_PINS_1_0 = 2'h1;
   localparam logic [1:0] KEY_PINS_2_0 = 2'h2;
   localparam logic [1:0] KEY_PINS_3_0 = 2'h3;

   // Pins present on this variant, one mask per port; absent bits read zero
   localparam logic [7:0] PORT0_PRESENT = 8'hff;
   localparam logic [7:0] PORT1_PRESENT = 8'hff;
   localparam logic [7:0] PORT2_PRESENT = 8'hff;
   localparam logic [7:0] PORT3_PRESENT = 8'hff;
   localparam logic [7:0] PORT4_PRESENT = 8'hff;
   localparam logic [7:0] PORT5_PRESENT = 8'h0f;

endpackage

`default_nettype wire

// *** pkrim_key_reset.sv ***
`timescale 1ns/1ps
`default_nettype none

module pkrim_key_reset (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] key_reset_select_i,
   input wire logic [3:0] key_pin_i,
   output logic key_reset_req_o
);

   logic [3:0] pin_ff;
   logic req_ff;
   logic [3:0] used_mask;
   wire all_low;

   always_comb begin
      used_mask = 4'h0;
      unique case (key_reset_select_i)
         pkrim_pkg::KEY_PINS_3_0: used_mask = 4'hf;
         pkrim_pkg::KEY_PINS_2_0: used_mask = 4'h7;
         pkrim_pkg::KEY_PINS_1_0: used_mask = 4'h3;
         pkrim_pkg::KEY_OFF: used_mask = 4'h0;
      endcase
   end

   // Every selected pin low at once; an empty selection never fires
   assign all_low = (used_mask != 4'h0) && ((pin_ff & used_mask) == 4'h0);

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_ff <= 4'hf;
         req_ff <= 1'b0;
      end else begin
         pin_ff <= key_pin_i;
         req_ff <= all_low;
      end
   end

   assign key_reset_req_o = req_ff;

endmodule

`default_nettype wire

// *** pkrim_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pkrim_props (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] port0_pin_i,
   input wire logic [7:0] port5_input_data_o,
   input wire logic [3:0] low_pin_out_o,
   input wire logic remote_transmit_out_i,
   input wire logic remote_receive_in_o,
   input wire logic adc_trigger_input_n_o,
   input wire logic timer_ext_clock_in_o,
   input wire logic key_reset_req_o
);
   logic [1:0] sel_ff;
   logic [7:0] fsel_ff;
   logic [3:0] mask;
   logic hit;
   assign mask = {sel_ff == 2'h3, sel_ff[1], sel_ff != 2'h0, sel_ff != 2'h0};
   assign hit = (sel_ff != 2'h0) && ((port0_pin_i[3:0] & mask) == 4'h0);
   // Shadow copies of the two configuration registers
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sel_ff <= 2'h0;
         fsel_ff <= 8'h00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == pkrim_pkg::KEY_RESET_CONFIG_OFS) sel_ff <= reg_wdata_i[1:0];
         if (reg_addr_i == pkrim_pkg::LOW_PIN_FUNCTION_SELECT_OFS) fsel_ff <= reg_wdata_i;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_low2; hit ##1 (hit && $stable(sel_ff)); endsequence
   sequence s_high2; !hit ##1 (!hit && $stable(sel_ff)); endsequence
   a_key_fires: assert property (s_low2 |=> key_reset_req_o)
      else $error("key reset request missing");
   a_key_quiet: assert property (s_high2 |=> !key_reset_req_o)
      else $error("key reset request without all keys low");
   a_key_off: assert property (sel_ff == 2'h0 |=> !key_reset_req_o)
      else $error("key reset request while disabled");
   a_key_readback: assert property (reg_rd_i && reg_addr_i == 16'h5209
      |=> reg_rdata_o == {6'h00, $past(sel_ff)}) else $error("key config read wrong");
   a_absent_zero: assert property (port5_input_data_o[7:4] == 4'h0)
      else $error("absent pin reads nonzero");
   a_tx_route: assert property (fsel_ff[1:0] == 2'h1
      |=> low_pin_out_o[0] == $past(remote_transmit_out_i)) else $error("tx not routed");
   a_rx_idle: assert property (fsel_ff[3:2] != 2'h1 |=> !remote_receive_in_o)
      else $error("remote receive active while unrouted");
   a_trig_idle: assert property (fsel_ff[7:6] != 2'h1 |=> adc_trigger_input_n_o)
      else $error("trigger active while unrouted");
   a_timer_cut: assert property (fsel_ff[5:4] != 2'h0 |=> !timer_ext_clock_in_o)
      else $error("timer clock fed while reserved");
endmodule
bind pkrim_top pkrim_props pkrim_props_i (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .port0_pin_i, .port5_input_data_o, .low_pin_out_o,
   .remote_transmit_out_i, .remote_receive_in_o, .adc_trigger_input_n_o,
   .timer_ext_clock_in_o, .key_reset_req_o);
`default_nettype wire

// *** pkrim_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pkrim_pin_model (
   input wire logic [3:0] key_press_i,
   input wire logic [3:0] pad_out_i,
   input wire logic [3:0] pad_oe_i,
   input wire logic [3:0] upper_pin_i,
   output logic [7:0] port0_pin_o
);
   // A pressed key pulls low; an idle undriven pin rests high on its pull-up
   assign port0_pin_o[3:0] = (pad_oe_i & pad_out_i) | (~pad_oe_i & ~key_press_i);
   assign port0_pin_o[7:4] = upper_pin_i;
endmodule
`default_nettype wire

// *** port_key_reset_input_mux_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_key_reset_input_mux_tb;
   logic core_clk_i, sys_rst_i, wr, rd, tx, rx, trig_n, tclk, req;
   logic [15:0] addr;
   logic [7:0] wd, rdata, p0, e;
   logic [7:0] pin [6];
   logic [7:0] din [6];
   logic [3:0] keys, gout, goe, pout, poe, m;
   int bad_count, n_checks, cyc;
   logic [15:0] ofs [8] = '{16'h5209, 16'h520a, 16'h521a, 16'h522a, 16'h523a, 16'h524a,
      16'h525a, 16'h52a0};
   logic [7:0] msk [8] = '{8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff};
   pkrim_top pkrim_top_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .port0_pin_i(p0),
      .port1_pin_i(pin[1]), .port2_pin_i(pin[2]), .port3_pin_i(pin[3]), .port4_pin_i(pin[4]),
      .port5_pin_i(pin[5]), .port0_input_data_o(din[0]), .port1_input_data_o(din[1]),
      .port2_input_data_o(din[2]), .port3_input_data_o(din[3]), .port4_input_data_o(din[4]),
      .port5_input_data_o(din[5]), .gpio_low_out_i(gout), .gpio_low_oe_i(goe),
      .low_pin_out_o(pout), .low_pin_oe_o(poe), .remote_transmit_out_i(tx),
      .remote_receive_in_o(rx), .adc_trigger_input_n_o(trig_n), .timer_ext_clock_in_o(tclk),
      .key_reset_req_o(req));
   pkrim_pin_model pkrim_pin_model_i (.key_press_i(keys), .pad_out_i(pout), .pad_oe_i(poe),
      .upper_pin_i(4'h3), .port0_pin_o(p0));
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Values are taken at the call, so callers pass them settled; realigns to the next rising edge
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      #1;
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
      @(posedge core_clk_i);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      // Read data stand only after this edge has updated them
      #1;
      chk(rdata, exp);
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         finish_test;
      end
   end
   initial begin
      {sys_rst_i, wr, rd, tx, addr, wd, keys, gout, goe, bad_count, n_checks, cyc} = '0;
      sys_rst_i = 1'b1;
      for (int i = 0; i < 6; i++) pin[i] = 8'h00;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      for (int i = 0; i < 8; i++) rd_reg(ofs[i], 8'hff & msk[i] & {8{i inside {[1:6]}}});
      for (int i = 0; i < 8; i++) wr_reg(ofs[i], 8'ha5);
      for (int i = 0; i < 8; i++) rd_reg(ofs[i], 8'ha5 & msk[i]);
      wr_reg(16'h520b, 8'hff);
      rd_reg(16'h520b, 8'h00);
      wr_reg(16'h52a0, 8'h00);
      wr_reg(16'h5209, 8'h00);
      for (int i = 1; i < 6; i++) pin[i] <= 8'h3c ^ 8'(i);
      repeat (3) @(posedge core_clk_i);
      for (int i = 0; i < 6; i++) begin
         e = (i == 0) ? 8'h3f : 8'h3c ^ 8'(i);
         chk(din[i], e & msk[i + 1] & 8'ha5);
      end
      wr_reg(16'h520a, 8'hff);
      for (int s = 1; s < 4; s++) begin
         wr_reg(16'h5209, 8'(s));
         m = 4'((5'h02 << s) - 5'h01);
         keys <= m;
         repeat (3) @(posedge core_clk_i);
         chk({7'h00, req}, 8'h01);
         keys <= m & ~(4'h1 << s);
         repeat (3) @(posedge core_clk_i);
         chk({7'h00, req}, 8'h00);
         keys <= m;
         repeat (3) @(posedge core_clk_i);
      end
      keys <= 4'hf;
      wr_reg(16'h5209, 8'h00);
      #1;
      chk({7'h00, req}, 8'h00);
      wr_reg(16'h5209, 8'h03);
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk({7'h00, req}, 8'h00);
      rd_reg(16'h5209, 8'h00);
      for (int v = 0; v < 2; v++) begin
         keys <= v[0] ? 4'h0 : 4'h4;
         repeat (3) @(posedge core_clk_i);
         chk({7'h00, tclk}, 8'(v));
      end
      wr_reg(16'h520a, 8'hfb);
      #1;
      chk({7'h00, tclk}, 8'h00);
      wr_reg(16'h520a, 8'hff);
      wr_reg(16'h52a0, 8'h45);
      for (int v = 0; v < 2; v++) begin
         tx <= v[0];
         keys <= v[0] ? 4'h0 : 4'ha;
         repeat (3) @(posedge core_clk_i);
         chk({5'h00, trig_n, rx, pout[0]}, {5'h00, {3{v[0]}}});
      end
      wr_reg(16'h52a0, 8'hff);
      gout <= 4'h5;
      goe <= 4'hf;
      repeat (3) @(posedge core_clk_i);
      chk({poe, pout}, 8'hf5);
      chk({5'h00, trig_n, rx, tclk}, 8'h04);
      finish_test;
   end
endmodule
`default_nettype wire
